// ==== common/cascade_capture_pkg.sv ====
// Constants for the cascaded 32-bit input capture timer.
`default_nettype none
package cascade_capture_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] BASE_LOWER  = 7'h00;
   localparam logic [6:0] BASE_UPPER  = 7'h40;
   localparam logic [6:0] OFS_CTRL    = 7'h00;
   localparam logic [6:0] OFS_MODE    = 7'h04;
   localparam logic [6:0] OFS_COUNT   = 7'h08;
   localparam logic [6:0] OFS_PINFN   = 7'h0c;
   localparam logic [6:0] OFS_IRQEN   = 7'h10;
   localparam logic [6:0] OFS_STATUS  = 7'h14;
   localparam logic [6:0] OFS_GRA     = 7'h18;
   localparam logic [6:0] OFS_GRB     = 7'h1c;
   localparam logic [6:0] OFS_CASCADE = 7'h20;
   localparam logic [6:0] OFS_RUN     = 7'h24;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CLR_SRC_LSB = 5;
   localparam int EDGE_LSB    = 3;
   localparam int SRC_LSB     = 0;
   localparam int BUF_A_BIT   = 4;
   localparam int MODE_LSB    = 0;
   localparam int PIN_B_LSB   = 4;
   localparam int PIN_A_LSB   = 0;
   localparam int IRQ_A_BIT   = 0;
   localparam int IRQ_B_BIT   = 1;
   localparam int IRQ_OVF_BIT = 4;
   localparam int IRQ_UNF_BIT = 5;
   localparam int TRIG_BIT    = 7;
   localparam int RUN_CH1_BIT = 1;
   localparam int RUN_CH2_BIT = 2;

   // ----------------------------------------------------------------
   // Writable bit masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_MASK    = 8'h1f;
   localparam logic [7:0] IRQEN_MASK   = 8'hb3;
   localparam logic [7:0] STATUS_MASK  = 8'h33;
   localparam logic [7:0] CASCADE_MASK = 8'h0f;
   localparam logic [7:0] RUN_MASK     = 8'hc7;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_WORD    = 16'h0000;

   // ----------------------------------------------------------------
   // Field codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SRC_DIV1    = 3'h0;
   localparam logic [2:0] SRC_DIV64   = 3'h3;
   localparam logic [2:0] SRC_CASCADE = 3'h7;
   localparam logic [2:0] CLR_NONE    = 3'h0;
   localparam logic [2:0] CLR_ON_A    = 3'h1;
   localparam logic [2:0] CLR_ON_B    = 3'h2;
   localparam logic [1:0] EDGE_RISE   = 2'h0;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [15:0] COUNT_TOP  = 16'hffff;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int PRESCALE_DIV = 64;

endpackage
`default_nettype wire

// ==== verilog/capture_edge_sync.sv ====
// Three-stage pin synchroniser with rise and fall detection.
`timescale 1ns/100ps
`default_nettype none
module capture_edge_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;

   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_reg[i]    <= 1'b0;
            s2_reg[i]    <= 1'b0;
            s3_reg[i]    <= 1'b0;
            level_reg[i] <= 1'b0;
         end else begin
            s1_reg[i] <= pin_in[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i]) begin
               level_reg[i] <= s3_reg[i];
            end
         end
      end

      // A change counts once the second and third stages agree.
      assign rise[i] = s2_reg[i] & s3_reg[i] & ~level_reg[i];
      assign fall[i] = ~s2_reg[i] & ~s3_reg[i] & level_reg[i];
   end

endmodule // capture_edge_sync
`default_nettype wire

// ==== verilog/cascaded_capture_timer.sv ====
// Two 16-bit timer channels cascaded into a 32-bit capture timer.
//
// How it works
// - Lower and upper channel counters form one 32-bit count.
// - Source 111 advances the upper count on each lower wrap.
// - Source 011 advances the count from the timer clock over 64.
// - Clear source 000 never clears; the count wraps freely.
// - Edge select 00 counts on rising edges of the source.
// - Mode field selects timer mode; 0000 is normal mode.
// - Buffer select 0 keeps registers A and C independent.
// - Pin function A 1000 captures the count on a pin A rise.
// - Pin function B 0000 makes B a compare, pin level kept.
// - Cascade bit 2 lets lower pin A capture into upper reg A.
// - Bits 3, 1, 0 route the other pins likewise; 0 excludes.
// - Both halves are captured in the same cycle.
// - Enable bit 0 gates the register A interrupt request.
// - Enable bit 1 gates the register B interrupt request.
// - Bits 4 and 5 gate overflow and underflow requests.
// - Enable bit 7 gates converter start requests from reg A.
// - Start register bits 1 and 2 run or halt the upper and lower channels.
// - Lower count uses the timer clock; upper follows its wraps.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module cascaded_capture_timer
   import cascade_capture_pkg::*;
#(
   parameter int PRESCALE = cascade_capture_pkg::PRESCALE_DIV
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [6:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        upper_pin_a,
   input  wire logic        upper_pin_b,
   input  wire logic        lower_pin_a,
   input  wire logic        lower_pin_b,
   output wire logic [1:0]  reg_a_irq,
   output wire logic [1:0]  reg_b_irq,
   output wire logic [1:0]  overflow_irq,
   output wire logic [1:0]  underflow_irq,
   output wire logic [1:0]  converter_start
);

   localparam int PW = $clog2(PRESCALE);
   localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

   // Index 0 is the lower half, index 1 the upper half.
   logic [7:0]  ctrl_reg    [2];
   logic [7:0]  mode_reg    [2];
   logic [7:0]  pinfn_reg   [2];
   logic [7:0]  irqen_reg   [2];
   logic [7:0]  flags_reg   [2];
   logic [15:0] count_reg   [2];
   logic [15:0] gra_reg     [2];
   logic [15:0] grb_reg     [2];
   logic [4:0]  irq_reg     [2];
   logic [7:0]  cascade_reg;
   logic [7:0]  run_reg;
   logic [PW-1:0] pre_reg;
   logic        pre_tick;
   logic [1:0]  ovf;
   logic [3:0]  pin_rise;
   logic [3:0]  pin_fall;
   logic        wr_go;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Pins come from outside the clock domain and pass three stages.
   // Pin order: lower A, lower B, upper A, upper B.
   capture_edge_sync #(
      .WIDTH (4)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  ({upper_pin_b, upper_pin_a, lower_pin_b, lower_pin_a}),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic wr_hit(input logic [6:0] ofs);
      wr_hit = wr_go && (avs_address[6:2] == ofs[6:2]);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old);
      merge16[7:0]  = avs_byteenable[0] ? avs_writedata[7:0]  : old[7:0];
      merge16[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : old[15:8];
   endfunction

   // Capture edge for pin functions 1000 rise, 1001 fall, 101x both.
   function automatic logic edge_hit(input logic [3:0] fn,
                                     input logic r, input logic f);
      edge_hit = fn[3] && (fn[1] ? (r | f) : (fn[0] ? f : r));
   endfunction

   // ----------------------------------------------------------------
   // Avalon slave: one wait cycle, answer on the second edge
   // ----------------------------------------------------------------
   assign wr_go = avs_write && !avs_waitrequest;

   // Read data load only on reads, so an answer stands until the next
   // read is answered, whatever writes come between.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         if (avs_read) begin
            avs_readdata <= rd_mux;
         end
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      logic c;
      c = avs_address[6];
      rd_mux = 32'h0000_0000;
      if (!avs_address[5]) begin
         unique case (avs_address[4:2])
            OFS_CTRL[4:2]:   rd_mux[7:0]  = ctrl_reg[c];
            OFS_MODE[4:2]:   rd_mux[7:0]  = mode_reg[c];
            OFS_COUNT[4:2]:  rd_mux[15:0] = count_reg[c];
            OFS_PINFN[4:2]:  rd_mux[7:0]  = pinfn_reg[c];
            OFS_IRQEN[4:2]:  rd_mux[7:0]  = irqen_reg[c];
            OFS_STATUS[4:2]: rd_mux[7:0]  = flags_reg[c];
            OFS_GRA[4:2]:    rd_mux[15:0] = gra_reg[c];
            OFS_GRB[4:2]:    rd_mux[15:0] = grb_reg[c];
         endcase
      end else if (avs_address[6:2] == OFS_CASCADE[6:2]) begin
         rd_mux[7:0] = cascade_reg;
      end else if (avs_address[6:2] == OFS_RUN[6:2]) begin
         rd_mux[7:0] = run_reg;
      end
   end

   // ----------------------------------------------------------------
   // Shared registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cascade_reg <= RST_BYTE;
      end else if (wr_hit(OFS_CASCADE) && avs_byteenable[0]) begin
         cascade_reg <= avs_writedata[7:0] & CASCADE_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= RST_BYTE;
      end else if (wr_hit(OFS_RUN) && avs_byteenable[0]) begin
         run_reg <= avs_writedata[7:0] & RUN_MASK;
      end
   end

   // Free-running divider of the timer clock.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_tick ? '0 : pre_reg + 1'b1;
      end
   end
   assign pre_tick = (pre_reg == PRE_LAST);

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      localparam logic [6:0] BASE = (ch == 1) ? BASE_UPPER : BASE_LOWER;
      localparam int PA = (ch == 1) ? 2 : 0;
      localparam int QA = 2 - PA;
      localparam int RUN_BIT = (ch == 1) ? RUN_CH1_BIT : RUN_CH2_BIT;

      logic       casc_in;
      logic [2:0] src;
      logic [2:0] clr_src;
      logic [1:0] edge_sel;
      logic [3:0] fn_a;
      logic [3:0] fn_b;
      logic       tick;
      logic       advance;
      logic       cap_a;
      logic       cap_b;
      logic       ev_a;
      logic       ev_b;
      logic       clear;
      logic [7:0] set_bits;
      logic [7:0] clr_bits;
      logic [7:0] flags_next;

      // Only the upper half has a cascade input to count on.
      if (ch == 1) begin : g_upper
         assign casc_in = ovf[0];
      end else begin : g_lower
         assign casc_in = 1'b0;
      end

      assign src      = ctrl_reg[ch][SRC_LSB +: 3];
      assign clr_src  = ctrl_reg[ch][CLR_SRC_LSB +: 3];
      assign edge_sel = ctrl_reg[ch][EDGE_LSB +: 2];
      assign fn_a     = pinfn_reg[ch][PIN_A_LSB +: 4];
      assign fn_b     = pinfn_reg[ch][PIN_B_LSB +: 4];

      // Each tick is one rising edge of the selected source; the
      // other edge selections count the same single event.
      assign tick = (src == SRC_DIV1)
                  || ((src == SRC_DIV64) && pre_tick)
                  || ((src == SRC_CASCADE) && casc_in);
      assign advance = run_reg[RUN_BIT] && tick
                     && (mode_reg[ch][MODE_LSB +: 4] == MODE_NORMAL);
      assign ovf[ch] = advance && (count_reg[ch] == COUNT_TOP);

      assign cap_a = edge_hit(fn_a, pin_rise[PA], pin_fall[PA])
         || (cascade_reg[PA]
             && edge_hit(fn_a, pin_rise[QA], pin_fall[QA]));
      assign cap_b = edge_hit(fn_b, pin_rise[PA+1], pin_fall[PA+1])
         || (cascade_reg[PA+1]
             && edge_hit(fn_b, pin_rise[QA+1], pin_fall[QA+1]));

      // Compare matches when the register is not a capture; the pin
      // itself is left at its level.
      assign ev_a = cap_a
         || (!fn_a[3] && advance && count_reg[ch] == gra_reg[ch]);
      assign ev_b = cap_b
         || (!fn_b[3] && advance && count_reg[ch] == grb_reg[ch]);

      assign clear = ((clr_src == CLR_ON_A) && ev_a)
                   || ((clr_src == CLR_ON_B) && ev_b);

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            count_reg[ch] <= RST_WORD;
         end else if (wr_hit(BASE + OFS_COUNT)) begin
            count_reg[ch] <= merge16(count_reg[ch]);
         end else if (clear) begin
            count_reg[ch] <= RST_WORD;
         end else if (advance) begin
            count_reg[ch] <= count_reg[ch] + 16'h0001;
         end
      end

      // Captures take the count before this cycle's update, so both
      // halves latch one consistent 32-bit value in the same cycle.
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            gra_reg[ch] <= RST_WORD;
         end else if (cap_a) begin
            gra_reg[ch] <= count_reg[ch];
         end else if (wr_hit(BASE + OFS_GRA)) begin
            gra_reg[ch] <= merge16(gra_reg[ch]);
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            grb_reg[ch] <= RST_WORD;
         end else if (cap_b) begin
            grb_reg[ch] <= count_reg[ch];
         end else if (wr_hit(BASE + OFS_GRB)) begin
            grb_reg[ch] <= merge16(grb_reg[ch]);
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            ctrl_reg[ch]  <= RST_BYTE;
            mode_reg[ch]  <= RST_BYTE;
            pinfn_reg[ch] <= RST_BYTE;
            irqen_reg[ch] <= RST_BYTE;
         end else if (avs_byteenable[0]) begin
            if (wr_hit(BASE + OFS_CTRL)) begin
               ctrl_reg[ch] <= avs_writedata[7:0];
            end
            if (wr_hit(BASE + OFS_MODE)) begin
               mode_reg[ch] <= avs_writedata[7:0] & MODE_MASK;
            end
            if (wr_hit(BASE + OFS_PINFN)) begin
               pinfn_reg[ch] <= avs_writedata[7:0];
            end
            if (wr_hit(BASE + OFS_IRQEN)) begin
               irqen_reg[ch] <= avs_writedata[7:0] & IRQEN_MASK;
            end
         end
      end

      // Software clears a flag by writing 0 to it; a new event in the
      // same cycle keeps it set. The count only rises in normal mode,
      // so no underflow event occurs.
      always_comb begin
         set_bits = 8'h00;
         set_bits[IRQ_A_BIT]   = ev_a;
         set_bits[IRQ_B_BIT]   = ev_b;
         set_bits[IRQ_OVF_BIT] = ovf[ch];
         clr_bits = 8'h00;
         if (wr_hit(BASE + OFS_STATUS) && avs_byteenable[0]) begin
            clr_bits = ~avs_writedata[7:0] & STATUS_MASK;
         end
         flags_next = (flags_reg[ch] & ~clr_bits) | set_bits;
      end

      // A request follows an enable write one cycle late, as it is formed
      // from the stored enable bits.
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            flags_reg[ch] <= RST_BYTE;
            irq_reg[ch]   <= 5'h00;
         end else begin
            flags_reg[ch] <= flags_next;
            irq_reg[ch][0] <= flags_next[IRQ_A_BIT]
                              & irqen_reg[ch][IRQ_A_BIT];
            irq_reg[ch][1] <= flags_next[IRQ_B_BIT]
                              & irqen_reg[ch][IRQ_B_BIT];
            irq_reg[ch][2] <= flags_next[IRQ_OVF_BIT]
                              & irqen_reg[ch][IRQ_OVF_BIT];
            irq_reg[ch][3] <= flags_next[IRQ_UNF_BIT]
                              & irqen_reg[ch][IRQ_UNF_BIT];
            irq_reg[ch][4] <= ev_a & irqen_reg[ch][TRIG_BIT];
         end
      end

      assign reg_a_irq[ch]       = irq_reg[ch][0];
      assign reg_b_irq[ch]       = irq_reg[ch][1];
      assign overflow_irq[ch]    = irq_reg[ch][2];
      assign underflow_irq[ch]   = irq_reg[ch][3];
      assign converter_start[ch] = irq_reg[ch][4];
   end

endmodule // cascaded_capture_timer
`default_nettype wire

// ==== tb/pulse_source.sv ====
// Pulse source model that drives the four capture pins.
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] pulse_req,
   output logic      [3:0] pins
);
   logic [3:0] hold_cnt;

   // A request raises its pins for six clocks, well above the shortest pulse.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= 4'h0;
         hold_cnt <= 4'h0;
      end else if (pulse_req != 4'h0) begin
         pins <= pulse_req;
         hold_cnt <= 4'h6;
      end else if (hold_cnt != 4'h0) begin
         hold_cnt <= hold_cnt - 4'h1;
         if (hold_cnt == 4'h1) begin
            pins <= 4'h0;
         end
      end
   end
endmodule // pulse_source
`default_nettype wire

// ==== tb/cascaded_capture_timer_monitor.sv ====
// Concurrent checks on the ports of the cascaded capture timer.
`timescale 1ns/100ps
`default_nettype none
module cascaded_capture_timer_monitor (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  reg_a_irq,
   input wire logic [1:0]  reg_b_irq,
   input wire logic [1:0]  overflow_irq,
   input wire logic [1:0]  underflow_irq,
   input wire logic [1:0]  converter_start
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("Request not answered in one cycle.");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("Wait request low for more than one cycle.");
   chk_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("Answer given without a request.");
   chk_read_hold: assert property (!(avs_read && avs_waitrequest)
      |=> $stable(avs_readdata)) else $error("Read data changed unasked.");
   chk_no_underflow: assert property (underflow_irq == 2'b00)
      else $error("Underflow request raised on a rising count.");
   chk_start_pulse: assert property (converter_start != 2'b00
      |=> (converter_start & $past(converter_start)) == 2'b00)
      else $error("Converter start longer than one cycle.");
   chk_irq_a_hold: assert property (reg_a_irq != 2'b00
      && !avs_write && !$past(avs_write)
      |=> (reg_a_irq & $past(reg_a_irq)) == $past(reg_a_irq))
      else $error("Register A request dropped without a write.");
   chk_irq_b_hold: assert property (reg_b_irq != 2'b00
      && !avs_write && !$past(avs_write)
      |=> (reg_b_irq & $past(reg_b_irq)) == $past(reg_b_irq))
      else $error("Register B request dropped without a write.");
   chk_ovf_hold: assert property (overflow_irq != 2'b00
      && !avs_write && !$past(avs_write)
      |=> (overflow_irq & $past(overflow_irq)) == $past(overflow_irq))
      else $error("Overflow request dropped without a write.");
endmodule // cascaded_capture_timer_monitor

bind cascaded_capture_timer cascaded_capture_timer_monitor mon_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .reg_a_irq(reg_a_irq),
   .reg_b_irq(reg_b_irq), .overflow_irq(overflow_irq),
   .underflow_irq(underflow_irq), .converter_start(converter_start));
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the cascaded capture timer.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct {logic [6:0] a; logic [15:0] d; logic [15:0] e;} row_t;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [6:0]  avs_address = 7'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [3:0]  pulse_req = 4'h0;
   logic [3:0]  pins;
   logic [1:0]  reg_a_irq, reg_b_irq, overflow_irq, underflow_irq;
   logic [1:0]  converter_start;
   logic [1:0]  start_seen = 2'b00;
   int          err_total = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic [31:0] q, lo, lg, m;
   logic [15:0] cnt [2];
   row_t        rows [8] = '{'{7'h04, 16'h00ff, 16'h001f},
      '{7'h10, 16'h00ff, 16'h00b3}, '{7'h20, 16'h00ff, 16'h000f},
      '{7'h24, 16'h00f9, 16'h00c1}, '{7'h48, 16'h1234, 16'h1234},
      '{7'h4c, 16'h00a8, 16'h00a8}, '{7'h00, 16'h00ff, 16'h00ff},
      '{7'h28, 16'h00ff, 16'h0000}};

   cascaded_capture_timer #(.PRESCALE(4)) dut_u (.sys_clk(sys_clk),
      .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .upper_pin_a(pins[0]),
      .upper_pin_b(pins[1]), .lower_pin_a(pins[2]), .lower_pin_b(pins[3]),
      .reg_a_irq(reg_a_irq), .reg_b_irq(reg_b_irq),
      .overflow_irq(overflow_irq), .underflow_irq(underflow_irq),
      .converter_start(converter_start));
   pulse_source src_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .pulse_req(pulse_req), .pins(pins));

   initial forever #20 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      start_seen <= start_seen | converter_start;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic check_true(input logic c, input string msg);
      check({31'h0, c}, 32'h1, msg);
   endtask
   task automatic bus(input logic [6:0] a, input logic w, input logic [15:0] d,
                      output logic [31:0] r);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= 4'h3;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [31:0] unused;
      bus(a, 1'b1, d, unused);
   endtask
   task automatic rd(input logic [6:0] a, output logic [31:0] r);
      bus(a, 1'b0, 16'h0000, r);
   endtask
   task automatic pulse(input logic [3:0] which);
      @(posedge sys_clk);
      pulse_req <= which;
      @(posedge sys_clk);
      pulse_req <= 4'h0;
      repeat (16) @(posedge sys_clk);
   endtask
   task automatic measure(input logic [15:0] src, output logic [15:0] c);
      logic [31:0] r;
      wr(7'h24, 16'h0);
      wr(7'h08, 16'h0);
      wr(7'h00, src);
      wr(7'h24, 16'h4);
      repeat (40) @(posedge sys_clk);
      wr(7'h24, 16'h0);
      rd(7'h08, r);
      c = r[15:0];
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk);
      check_true(avs_waitrequest === 1'b1 && reg_a_irq === 2'b00, "reset out");
      rst_n <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         rd(7'(i * 4), q);
         check(q, 32'h0, "reset value");
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, q);
         check(q, {16'h0, rows[i].e}, "readback");
      end
      // Cascaded capture: lower by 4 from near its top, upper on wraps.
      wr(7'h00, 16'h03);
      wr(7'h04, 16'h00);
      wr(7'h0c, 16'h08);
      wr(7'h10, 16'h91);
      wr(7'h08, 16'hfff8);
      wr(7'h40, 16'h07);
      wr(7'h44, 16'h00);
      wr(7'h48, 16'h0005);
      wr(7'h4c, 16'h08);
      wr(7'h50, 16'h00);
      wr(7'h20, 16'h04);
      wr(7'h24, 16'h06);
      repeat (60) @(posedge sys_clk);
      check({30'h0, overflow_irq}, 32'h1, "overflow request");
      pulse(4'h4);
      check({30'h0, reg_a_irq}, 32'h1, "capture request");
      check({30'h0, start_seen}, 32'h1, "converter start");
      wr(7'h24, 16'h00);
      rd(7'h58, q);
      check(q, 32'h6, "upper capture");
      rd(7'h18, lg);
      rd(7'h08, lo);
      rd(7'h48, q);
      check(q, 32'h6, "upper count");
      check_true(lg[15:0] < lo[15:0], "lower capture");
      rd(7'h54, q);
      check(q, 32'h1, "upper flag");
      rd(7'h08, q);
      check(q, lo, "halted count");
      wr(7'h50, 16'h01);
      repeat (2) @(negedge sys_clk);
      check({30'h0, reg_a_irq}, 32'h3, "enable upper");
      wr(7'h54, 16'h00);
      @(negedge sys_clk);
      check({30'h0, reg_a_irq}, 32'h1, "flag clear");
      wr(7'h10, 16'h90);
      repeat (2) @(negedge sys_clk);
      check({30'h0, reg_a_irq}, 32'h0, "masked request");
      rd(7'h14, q);
      check(q, 32'h13, "lower flags kept");
      wr(7'h10, 16'h02);
      repeat (2) @(negedge sys_clk);
      check({30'h0, reg_b_irq}, 32'h1, "B request");
      // Prescaler rate against the plain timer clock.
      measure(16'h00, cnt[0]);
      measure(16'h03, cnt[1]);
      check_true(cnt[1] * 4 <= cnt[0] + 4 && cnt[1] * 4 + 4 >= cnt[0],
                 "divided rate");
      // Each cascade condition bit, excluded and then included.
      wr(7'h0c, 16'h88);
      wr(7'h4c, 16'h88);
      wr(7'h10, 16'h00);
      for (int k = 0; k < 4; k++) begin
         m = (k % 2 == 1) ? 32'h2 : 32'h1;
         for (int on = 0; on < 2; on++) begin
            wr(7'h20, (on == 1) ? 16'(1 << k) : 16'h0);
            wr(7'h14, 16'h0);
            wr(7'h54, 16'h0);
            pulse(4'(1 << k));
            rd((k < 2) ? 7'h14 : 7'h54, q);
            check(q & m, (on == 1) ? m : 32'h0, "cascade route");
         end
      end
      // Reset again in mid-run.
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check_true(avs_waitrequest === 1'b1 && overflow_irq === 2'b00, "mid reset");
      rst_n <= 1'b1;
      rd(7'h20, q);
      check(q, 32'h0, "cascade after reset");
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
